// ---- include/led_drv_defs.svh ----
`ifndef LED_DRV_DEFS_SVH
`define LED_DRV_DEFS_SVH
// channel and memory geometry
`define CHANNELS        48
`define GROUP_SIZE      16
`define GS_WIDTH        16
`define MAX_LINES       32
`define LINE_BITS       5
`define CH_BITS         6
// config register one field positions
`define CFG1_GLOBAL_LSB 0
`define CFG1_RED_LSB    3
`define CFG1_GREEN_LSB  12
`define CFG1_BLUE_LSB   21
`define CFG1_WIDTH      30
`define CFG2_WIDTH      8
// reset values
`define GLOBAL_RESET    3'h4
`define COLOR_RESET     9'h100
`define COLOR_FULL      9'h1ff
`define CFG2_RESET      8'h00
// config register two bit that selects the short segment
`define CFG2_SHORT_SEG  0
// segment lengths in grayscale clocks
`define SEG_LONG        257
`define SEG_SHORT       129
`endif

// ---- include/led_drv_pkg.sv ----
package led_drv_pkg;
  // command kinds carried from controller to driver
  typedef enum logic [1:0] {
    CMD_WRITE_GS,
    CMD_WRITE_CFG,
    CMD_SWAP,
    CMD_READ_OPEN
  } cmd_t;
  typedef struct packed {
    cmd_t        cmd;
    logic [4:0]  line;
    logic [5:0]  chan;
    logic [31:0] data;
  } word_t;
endpackage : led_drv_pkg

// ---- include/led_link_if.sv ----
`timescale 1ns/100ps
interface led_link_if;
  led_drv_pkg::word_t word;
  logic               valid;
  logic               ready;
  logic               grayscale_clock;
  logic [47:0]        open_led_flag;
  modport driver (input word, valid, grayscale_clock, output ready,
                  output open_led_flag);
  modport controller (output word, valid, grayscale_clock,
                      input ready, open_led_flag);
endinterface : led_link_if

// ---- hdl/led_word_fifo.sv ----
`timescale 1ns/100ps
module led_word_fifo #(
  parameter int WIDTH = 45,
  parameter int DEPTH = 4
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_ce,
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_valid,
  output logic                  o_ready,
  output logic [WIDTH-1:0]      o_data,
  output logic                  o_valid,
  input  wire logic             i_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;
  assign o_ready = (count != (AW+1)'(DEPTH));
  assign o_valid = (count != '0);
  assign o_data  = mem[rd_ptr];
  assign push    = i_ce & i_valid & o_ready;
  assign pop     = i_ce & o_valid & i_ready;
  // storage
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end
  // pointers and fill level
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : led_word_fifo

// ---- hdl/led_controller.sv ----
`timescale 1ns/100ps
`include "led_drv_defs.svh"
module led_controller (
  input  wire logic          i_clk,
  input  wire logic          i_rst_b,
  input  wire logic          i_ce,
  input  wire led_drv_pkg::word_t i_word,
  input  wire logic          i_valid,
  output logic               o_ready,
  input  wire logic          i_grayscale_clock_run,
  output logic [47:0]        o_open_led_flag,
  led_link_if.controller     link
);
  logic grayscale_clock_q;
  // forward words while the driver accepts them, swaps too, with no wait for a gap
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      link.word       <= '0;
      link.valid      <= 1'b0;
      grayscale_clock_q          <= 1'b0;
      o_open_led_flag <= '0;
    end else if (i_ce) begin
      if (!link.valid || link.ready) begin
        link.valid <= i_valid;
        link.word  <= i_word;
      end
      grayscale_clock_q          <= i_grayscale_clock_run ? ~grayscale_clock_q : 1'b0;
      o_open_led_flag <= link.open_led_flag;
    end
  end
  assign link.grayscale_clock = grayscale_clock_q;
  assign o_ready = !link.valid || link.ready;
endmodule : led_controller

// ---- hdl/led_driver.sv ----
`timescale 1ns/100ps
`include "led_drv_defs.svh"
module led_driver #(
  parameter int LINES = `MAX_LINES
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_ce,
  input  wire logic [47:0] i_open_sense,
  output logic [47:0]      o_sink_output,
  output logic [2:0]       o_global_brightness,
  output logic [8:0]       o_red_group_brightness,
  output logic [8:0]       o_green_group_brightness,
  output logic [8:0]       o_blue_group_brightness,
  output logic [4:0]       o_line,
  output logic             o_segment_gap,
  led_link_if.driver       link
);
  localparam int WW = $bits(led_drv_pkg::word_t);
  // 2 banks x 32 lines x 48 channels x 16 bits = 48 kbit
  logic [15:0] gs_mem [2*`MAX_LINES*`CHANNELS];
  logic [`CFG1_WIDTH-1:0] config_reg_one;
  logic [`CFG2_WIDTH-1:0] config_reg_two;
  logic        show_bank;
  logic [8:0]  seg_cnt;
  logic [4:0]  line;
  logic [2:0]  gs_s1, gs_s2, gs_s3;
  logic [47:0] sense_s1, sense_s2, sense_s3;
  logic [47:0] sense_q;
  logic        fifo_valid;
  logic [WW-1:0] fifo_data;
  led_drv_pkg::word_t cmd;
  logic        grayscale_clock_rise;
  logic [8:0]  seg_last;
  assign cmd = led_drv_pkg::word_t'(fifo_data);

  function automatic logic [11:0] mem_index(input logic bank,
                                            input logic [4:0] ln,
                                            input logic [5:0] ch);
    mem_index = {bank, ln, 6'h00} - {2'b00, bank, ln, 4'h0} + {6'h00, ch};
  endfunction : mem_index

  led_word_fifo #(.WIDTH(WW), .DEPTH(4)) u_fifo (
    .i_clk  (i_clk),
    .i_rst_b(i_rst_b),
    .i_ce   (i_ce),
    .i_data (link.word),
    .i_valid(link.valid),
    .o_ready(link.ready),
    .o_data (fifo_data),
    .o_valid(fifo_valid),
    .i_ready(1'b1)
  );

  // grayscale clock and open-sense pins pass three flops
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      gs_s1 <= '0; gs_s2 <= '0; gs_s3 <= '0;
      sense_s1 <= '0; sense_s2 <= '0; sense_s3 <= '0;
      sense_q <= '0;
    end else if (i_ce) begin
      gs_s1 <= {2'b00, link.grayscale_clock};
      gs_s2 <= gs_s1;
      gs_s3 <= gs_s2;
      sense_s1 <= i_open_sense;
      sense_s2 <= sense_s1;
      sense_s3 <= sense_s2;
      // a sense bit only changes once the last two stages agree
      sense_q <= (sense_s2 & sense_s3) | (sense_q & (sense_s2 | sense_s3));
    end
  end
  assign grayscale_clock_rise = gs_s2[0] & ~gs_s3[0];
  assign seg_last = config_reg_two[`CFG2_SHORT_SEG] ?
                    9'(`SEG_SHORT - 1) : 9'(`SEG_LONG - 1);

  // grayscale memory writes into the loading bank
  always_ff @(posedge i_clk) begin
    if (i_ce && fifo_valid && cmd.cmd == led_drv_pkg::CMD_WRITE_GS) begin
      gs_mem[mem_index(~show_bank, cmd.line, cmd.chan)] <=
        cmd.data[15:0];
    end
  end

  // configuration registers, applied to outputs at once
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      config_reg_one <= {`COLOR_RESET, `COLOR_RESET, `COLOR_RESET,
                         `GLOBAL_RESET};
      config_reg_two <= `CFG2_RESET;
    end else if (i_ce && fifo_valid &&
                 cmd.cmd == led_drv_pkg::CMD_WRITE_CFG) begin
      if (cmd.line[0]) config_reg_two <= cmd.data[`CFG2_WIDTH-1:0];
      else config_reg_one <= cmd.data[`CFG1_WIDTH-1:0];
    end
  end
  // brightness levels drive the analog current stage directly
  assign o_global_brightness = config_reg_one[`CFG1_GLOBAL_LSB +: 3];
  assign o_red_group_brightness = config_reg_one[`CFG1_RED_LSB +: 9];
  assign o_green_group_brightness = config_reg_one[`CFG1_GREEN_LSB +: 9];
  assign o_blue_group_brightness = config_reg_one[`CFG1_BLUE_LSB +: 9];

  // bank swap and segment / line counting
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      show_bank <= 1'b0;
      seg_cnt   <= '0;
      line      <= '0;
    end else if (i_ce) begin
      if (fifo_valid && cmd.cmd == led_drv_pkg::CMD_SWAP) begin
        show_bank <= ~show_bank;
        line      <= '0;
        seg_cnt   <= '0;
      end else if (grayscale_clock_rise) begin
        if (seg_cnt >= seg_last) begin // shorter segment chosen mid-count
          seg_cnt <= '0;
          line <= (line == 5'(LINES - 1)) ? '0 : line + 1'b1;
        end else begin
          seg_cnt <= seg_cnt + 1'b1;
        end
      end
    end
  end
  assign o_line = line;
  assign o_segment_gap = (seg_cnt == '0);

  // pwm compare, one memory read per channel; seg_cnt is the unscaled time base, zero-extended to 16 bits
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sink_output      <= '0;
      link.open_led_flag <= '0;
    end else if (i_ce) begin
      for (int c = 0; c < `CHANNELS; c++) begin
        o_sink_output[c] <= gs_mem[mem_index(show_bank, line, 6'(c))] >
                            {7'h00, seg_cnt};
        link.open_led_flag[c] <= o_sink_output[c] & sense_q[c];
      end
    end
  end
endmodule : led_driver

// ---- tb/led_link_checker.sv ----
`timescale 1ns/100ps
module led_link_checker (
  input  wire logic               i_clk,
  input  wire logic               i_rst_b,
  input  wire led_drv_pkg::word_t word,
  input  wire logic               valid,
  input  wire logic               ready,
  input  wire logic [47:0]        open_led_flag,
  input  wire logic [47:0]        o_sink_output,
  input  wire logic [2:0]         o_global_brightness
);
  logic [2:0] cfg_global;
  // remembers the brightness carried by the last config one word
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b)
      cfg_global <= 3'h4;
    else if (valid && ready && word.cmd == led_drv_pkg::CMD_WRITE_CFG
             && !word.line[0])
      cfg_global <= word.data[2:0];
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  chk_reset_sinks_off: assert property (
    $rose(i_rst_b) |-> o_sink_output == 48'h0) else $error("sinks on");
  chk_reset_global_four: assert property (
    $rose(i_rst_b) |-> o_global_brightness == 3'h4) else $error("global");
  chk_ready_at_release: assert property (
    $rose(i_rst_b) |-> ready) else $error("ready low after reset");
  chk_flag_off_zero: assert property (
    (open_led_flag & ~o_sink_output & ~$past(o_sink_output)) == 48'h0)
    else $error("open flag set on an off output");
  chk_hold_request: assert property (
    valid && !ready |=> valid && $stable(word)) else $error("word dropped");
  chk_global_applies: assert property (
    valid && ready && word.cmd == led_drv_pkg::CMD_WRITE_CFG && !word.line[0]
    |-> ##[1:3] o_global_brightness == cfg_global) else $error("global late");
endmodule : led_link_checker

// ---- tb/multiplexed_led_grayscale_driver_tb_top.sv ----
`timescale 1ns/100ps
module multiplexed_led_grayscale_driver_tb_top;
  logic               i_clk = 1'b0;
  logic               i_rst_b = 1'b0;
  led_drv_pkg::word_t u_word = '0;
  logic               u_valid = 1'b0;
  logic               u_ready;
  logic               grayscale_clock_run = 1'b0;
  logic [47:0]        sense = 48'h0;
  logic [47:0]        host_flag, sink;
  logic [2:0]         glob;
  logic [8:0]         red, green, blue;
  logic [4:0]         line_no;
  logic               gap;
  int                 n_mismatch = 0;
  int                 samples_checked = 0;
  led_link_if link ();
  // controller and driver face each other across the link
  led_controller i_led_controller (.i_clk, .i_rst_b, .i_ce(1'b1),
    .i_word(u_word), .i_valid(u_valid), .o_ready(u_ready),
    .i_grayscale_clock_run(grayscale_clock_run), .o_open_led_flag(host_flag), .link(link));
  led_driver #(.LINES(2)) i_led_driver (.i_clk, .i_rst_b, .i_ce(1'b1),
    .i_open_sense(sense), .o_sink_output(sink), .o_global_brightness(glob),
    .o_red_group_brightness(red), .o_green_group_brightness(green),
    .o_blue_group_brightness(blue), .o_line(line_no), .o_segment_gap(gap),
    .link(link));
  led_link_checker i_led_link_checker (.i_clk, .i_rst_b, .word(link.word),
    .valid(link.valid), .ready(link.ready),
    .open_led_flag(link.open_led_flag), .o_sink_output(sink),
    .o_global_brightness(glob));
  always #2 i_clk = ~i_clk;
  task automatic check(input string what, input logic [47:0] seen,
                       input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one user word, held until the controller takes it
  task automatic send(input led_drv_pkg::cmd_t c, input logic [4:0] ln,
                      input logic [5:0] ch, input logic [31:0] d);
    int k;
    @(posedge i_clk);
    #1;
    u_word = '{c, ln, ch, d};
    u_valid = 1'b1;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (u_ready !== 1'b1 && k < 50);
    if (k >= 50) check("send taken", 48'h0, 48'h1);
    #1;
    u_valid = 1'b0;
  endtask : send
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : idle
  // sinks are looked at inside a segment, never in its gap
  task automatic look(input logic [1:0] exp);
    int k;
    for (k = 0; k < 600 && gap !== 1'b0; k++) idle(1);
    check("sinks", {46'h0, sink[1:0]}, {46'h0, exp});
  endtask : look
  task automatic t_reset;
    check("sinks", sink, 48'h0);
    check("global", {45'h0, glob}, 48'h4);
    check("colours", {21'h0, red, green, blue}, {21'h0, 27'h4020100});
    $display("test reset done");
  endtask : t_reset
  task automatic t_config;
    int g;
    for (g = 0; g < 8; g++) begin
      send(led_drv_pkg::CMD_WRITE_CFG, 5'h0, 6'h0,
           {2'h0, 9'h1ff, 9'h0cc, 9'(g), 3'(g)});
      idle(4);
      check("global", {45'h0, glob}, 48'(g));
      check("colours", {21'h0, red, green, blue},
            {21'h0, 9'(g), 9'h0cc, 9'h1ff});
    end
    $display("test config done");
  endtask : t_config
  task automatic frame(input logic [15:0] v0, input logic [15:0] v1);
    int ln;
    for (ln = 0; ln < 2; ln++) begin
      send(led_drv_pkg::CMD_WRITE_GS, 5'(ln), 6'h0, {16'h0, v0});
      send(led_drv_pkg::CMD_WRITE_GS, 5'(ln), 6'h1, {16'h0, v1});
    end
  endtask : frame
  task automatic t_banks;
    grayscale_clock_run = 1'b1;
    frame(16'hffff, 16'h0000);
    send(led_drv_pkg::CMD_SWAP, 5'h0, 6'h0, 32'h0);
    sense = 48'h3; // open sense on both loaded channels; only channel 0, whose sink is on, reports it
    idle(20);
    look(2'b01);
    check("flags", {46'h0, link.open_led_flag[1:0]}, 48'h1);
    send(led_drv_pkg::CMD_READ_OPEN, 5'h0, 6'h0, 32'h0);
    idle(6);
    check("read flags", {46'h0, host_flag[1:0]}, 48'h1);
    frame(16'h0000, 16'hffff);
    look(2'b01);
    send(led_drv_pkg::CMD_SWAP, 5'h0, 6'h0, 32'h0);
    idle(20);
    look(2'b10);
    $display("test banks done");
  endtask : t_banks
  // grayscale clocks from one gap to the next, and the line step
  task automatic seg_len(input int exp);
    int n, k;
    logic pg, pc, l1;
    n = -1;
    pg = 1'b1;
    pc = 1'b1;
    l1 = 1'b0;
    for (k = 0; k < 3000; k++) begin
      idle(1);
      if (gap && !pg) begin
        if (n >= 0) break;
        n = 0;
        l1 = line_no[0];
      end
      if (link.grayscale_clock && !pc && n >= 0) n++;
      pg = gap;
      pc = link.grayscale_clock;
    end
    check("segment clocks", 48'(n), 48'(exp));
    check("scan line", {47'h0, line_no[0]}, {47'h0, ~l1});
  endtask : seg_len
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (5) @(posedge i_clk);
    #1;
    i_rst_b = 1'b1;
    t_reset;
    t_config;
    t_banks;
    seg_len(257);
    send(led_drv_pkg::CMD_WRITE_CFG, 5'h1, 6'h0, 32'h1);
    seg_len(129);
    $display("test segments done");
    wrap_up;
  end
  initial begin
    #60000;
    n_mismatch++;
    wrap_up;
  end
endmodule : multiplexed_led_grayscale_driver_tb_top
